// >>> shared/prio_pkg.sv
// constants and register map for the priority and external edge block
// What this block does
// - low field encodes level zero to seven
// - zero field means level eight when upper set
// - effective level is upper bit over field
// - upper bit set masks all user interrupts
// - upper bit means level above seven
// - nesting disable makes low field read-only
package prio_pkg;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] STATUS_OFF = 4'h0;
	localparam logic [ADDR_W-1:0] CORE_OFF = 4'h4;
	localparam logic [ADDR_W-1:0] ICTL1_OFF = 4'h8;
	localparam logic [ADDR_W-1:0] ICTL2_OFF = 4'hc;
	localparam int PRIO_LSB = 5;
	localparam int UPPER_BIT = 3;
	localparam int NEST_BIT = 15;
	localparam int HOLD_BIT = 14;
	localparam int ALTVT_BIT = 15;
	localparam int NUM_EXT = 5;
	localparam logic [2:0] PRIO_RESET = 3'h0;
	localparam logic [2:0] PRIO_MAX = 3'h7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : prio_pkg

// >>> rtl/ext_edge_detect.sv
// one external request input: synchroniser and selectable edge detector
module ext_edge_detect (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic pin_in,
	input wire logic falling_sel,
	output logic edge_pulse
);
	logic meta_ff;
	logic sync_ff;
	logic last_ff;
	logic rise_w;
	logic fall_w;
	// two-stage synchroniser, then one history stage for edge detection
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			last_ff <= 1'b0;
			edge_pulse <= 1'b0;
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
			edge_pulse <= falling_sel ? fall_w : rise_w;
		end
	end
	assign rise_w = sync_ff & ~last_ff;
	assign fall_w = ~sync_ff & last_ff;
endmodule : ext_edge_detect

// >>> rtl/prio_edge_ctrl.sv
// processor priority level and external edge control with axi4-lite registers
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
module prio_edge_ctrl
	import prio_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic hold_active_in,
	input wire logic [NUM_EXT-1:0] ext_irq_pin,
	output logic [NUM_EXT-1:0] ext_irq_req,
	output logic [3:0] cpu_priority,
	output logic user_irq_masked
);
	logic [2:0] prio_low_ff;
	logic prio_upper_ff;
	logic nest_dis_ff;
	logic alt_vt_ff;
	logic [NUM_EXT-1:0] edge_sel_ff;
	logic hold_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [1:0] wstrb_ff;
	logic aw_have_ff;
	logic w_have_ff;
	logic [NUM_EXT-1:0] edge_w;
	// write happens once both address and data are held and no response pends
	logic do_write;
	logic wr_status, wr_core, wr_ictl1, wr_ictl2, wr_known;
	logic lo_en, hi_en;
	logic [15:0] rd_word;
	logic rd_known;
	logic [3:0] nxt_priority;

	assign do_write = aw_have_ff & w_have_ff & ~s_axi_bvalid;
	assign wr_status = do_write & (awaddr_ff == STATUS_OFF);
	assign wr_core = do_write & (awaddr_ff == CORE_OFF);
	assign wr_ictl1 = do_write & (awaddr_ff == ICTL1_OFF);
	assign wr_ictl2 = do_write & (awaddr_ff == ICTL2_OFF);
	assign wr_known = wr_status | wr_core | wr_ictl1 | wr_ictl2;
	assign lo_en = wstrb_ff[0];
	assign hi_en = wstrb_ff[1];
	assign nxt_priority = {prio_upper_ff, prio_low_ff};

	// address and data channels accepted independently, in either order
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_have_ff & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~w_have_ff & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_have_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end else if (do_write) begin
				aw_have_ff <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_have_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb[1:0];
			end else if (do_write) begin
				w_have_ff <= 1'b0;
			end
		end
	end

	// write response; unmapped offsets answer slverr
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// priority field: writable only while nesting is enabled
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			prio_low_ff <= PRIO_RESET;
		end else if (wr_status & lo_en & ~nest_dis_ff) begin
			prio_low_ff <= wdata_ff[PRIO_LSB +: 3];
		end
	end

	// control bits held in the core and interrupt control words
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			prio_upper_ff <= 1'b0;
			nest_dis_ff <= 1'b0;
			alt_vt_ff <= 1'b0;
			edge_sel_ff <= '0;
		end else begin
			if (wr_core & lo_en)
				prio_upper_ff <= wdata_ff[UPPER_BIT];
			if (wr_ictl1 & hi_en)
				nest_dis_ff <= wdata_ff[NEST_BIT];
			if (wr_ictl2 & hi_en)
				alt_vt_ff <= wdata_ff[ALTVT_BIT];
			if (wr_ictl2 & lo_en)
				edge_sel_ff <= wdata_ff[NUM_EXT-1:0];
		end
	end

	// hold status sampled from the core, which shares this clock
	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			hold_ff <= 1'b0;
		else
			hold_ff <= hold_active_in;
	end

	// read mux; every register is 16 bits, upper half reads zero
	always_comb begin
		rd_word = 16'h0000;
		rd_known = 1'b1;
		case (s_axi_araddr)
			STATUS_OFF: rd_word[PRIO_LSB +: 3] = prio_low_ff;
			CORE_OFF: rd_word[UPPER_BIT] = prio_upper_ff;
			ICTL1_OFF: rd_word[NEST_BIT] = nest_dis_ff;
			ICTL2_OFF: begin
				rd_word[ALTVT_BIT] = alt_vt_ff;
				rd_word[HOLD_BIT] = hold_ff;
				rd_word[NUM_EXT-1:0] = edge_sel_ff;
			end
			default: rd_known = 1'b0;
		endcase
	end

	// read channel: one read at a time, answered the cycle after arready
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {16'h0000, rd_word};
				s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// level outputs to the core; the upper bit or a low field of seven masks every user request
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cpu_priority <= 4'h0;
			user_irq_masked <= 1'b0;
			ext_irq_req <= '0;
		end else begin
			cpu_priority <= nxt_priority;
			user_irq_masked <= prio_upper_ff | (prio_low_ff == PRIO_MAX);
			ext_irq_req <= edge_w;
		end
	end

	// one detector per external input
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
			ext_edge_detect u_edge (
				.sys_clk(sys_clk),
				.reset_n(reset_n),
				.pin_in(ext_irq_pin[gi]),
				.falling_sel(edge_sel_ff[gi]),
				.edge_pulse(edge_w[gi])
			);
		end
	endgenerate
endmodule : prio_edge_ctrl

// >>> bench/prio_edge_ctrl_props.sv
// checker for the priority and edge block ports
module prio_edge_chk
	import prio_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_EXT-1:0] ext_irq_pin,
	input wire logic [NUM_EXT-1:0] ext_irq_req,
	input wire logic [3:0] cpu_priority,
	input wire logic user_irq_masked
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// masking follows the level
	AST_UPPER_MASKS: assert property (cpu_priority[3] |-> user_irq_masked)
		else $error("upper level not masked");
	AST_SEVEN_MASKS: assert property (cpu_priority == 4'h7 |-> user_irq_masked)
		else $error("level seven not masked");
	AST_LOW_OPEN: assert property (cpu_priority < 4'h7 |-> !user_irq_masked)
		else $error("low level masked");
	// level moves only around a write response
	AST_PRIO_ON_WRITE: assert property ($changed(cpu_priority) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("level moved without write");
	// a request is a lone pulse caused by a pin change
	AST_REQ_PULSE: assert property (ext_irq_req[0] |=> !ext_irq_req[0])
		else $error("request longer than one cycle");
	AST_REQ_CAUSE: assert property (ext_irq_req[0] |-> $past(ext_irq_pin[0], 2) != $past(ext_irq_pin[0], 6))
		else $error("request without pin edge");
	AST_QUIET_PINS: assert property ($stable(ext_irq_pin) [*6] |=> ext_irq_req == '0)
		else $error("request from quiet pins");
	AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	C_REQ: cover property (ext_irq_req != '0);
	C_EIGHT: cover property (cpu_priority == 4'h8);
	C_SEVEN: cover property (user_irq_masked && !cpu_priority[3]);
endmodule : prio_edge_chk
bind prio_edge_ctrl prio_edge_chk chk_u (.sys_clk, .reset_n, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
	.s_axi_rready, .ext_irq_pin, .ext_irq_req, .cpu_priority, .user_irq_masked);

// >>> bench/irq_src_model.sv
// far side stand-in: core hold state and request pins
module irq_src_model (
	input wire logic sys_clk,
	input wire logic [4:0] pin_lvl,
	input wire logic hold_cmd,
	output logic [4:0] ext_irq_pin,
	output logic hold_active_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// quiet pins until the core drives them
	initial begin
		ext_irq_pin = '0;
		hold_active_in = '0;
	end
	// pins follow the commands one clock late
	always @(posedge sys_clk) begin
		ext_irq_pin <= pin_lvl;
		hold_active_in <= hold_cmd;
	end
endmodule : irq_src_model

// >>> bench/test_prio_edge_ctrl.sv
// self-checking bench for the priority and edge block
module test_prio_edge_ctrl
	import prio_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = '0, reset_n = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0, hold_cmd = '0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'h3, cpu_priority;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, user_irq_masked, hold_active_in;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [4:0] ext_irq_pin, ext_irq_req, seen, pin_lvl = '0;
	int bad_count = 0, cmp_count = 0;
	prio_edge_ctrl dut_u (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.hold_active_in, .ext_irq_pin, .ext_irq_req, .cpu_priority, .user_irq_masked);
	irq_src_model src_u (.sys_clk, .pin_lvl, .hold_cmd, .ext_irq_pin, .hold_active_in);
	// 40 MHz clock
	initial forever #12.5 sys_clk = ~sys_clk;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// write: both channels offered together, bready held until answer
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= '1;
		s_axi_wvalid <= '1;
		s_axi_bready <= '1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= '0;
			if (s_axi_wready) s_axi_wvalid <= '0;
		end while (!s_axi_bvalid);
		s_axi_bready <= '0;
		chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
		@(negedge sys_clk);
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= '1;
		s_axi_rready <= '1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= '0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= '0;
		@(negedge sys_clk);
	endtask : rd
	// write, then level and mask must follow
	task automatic lvl(input logic [3:0] a, input logic [31:0] v, input logic [3:0] p);
		wr(a, v);
		chk("prio", 32'(p), 32'(cpu_priority));
		chk("mask", 32'(p[3] | (p == 4'h7)), 32'(user_irq_masked));
	endtask : lvl
	// all pins rise, then fall; only the selected edge may request
	task automatic edges(input logic [4:0] s);
		wr(ICTL2_OFF, 32'(s));
		for (int k = 0; k < 2; k++) begin
			@(posedge sys_clk);
			seen = '0;
			pin_lvl <= k ? 5'h00 : 5'h1f;
			repeat (8) begin
				@(posedge sys_clk);
				seen |= ext_irq_req;
			end
			chk("req", 32'(k ? s : 5'(~s)), 32'(seen));
		end
	endtask : edges
	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	// watchdog, far beyond the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		test_done;
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		reset_n <= '1;
		for (int i = 0; i < 4; i++) begin
			rd(4'(4 * i));
			chk("reset", '0, d);
		end
		for (int i = 0; i < 8; i++) lvl(STATUS_OFF, 32'(i) << 5, 4'(i));
		lvl(CORE_OFF, 32'h8, 4'hf);
		lvl(STATUS_OFF, 32'h0, 4'h8);
		lvl(STATUS_OFF, 32'ha0, 4'hd);
		lvl(CORE_OFF, 32'h0, 4'h5);
		wr(ICTL1_OFF, 32'h8000);
		lvl(STATUS_OFF, 32'h40, 4'h5);
		wr(ICTL1_OFF, 32'h0);
		lvl(STATUS_OFF, 32'h40, 4'h2);
		// high byte strobe alone must leave the low field untouched
		@(posedge sys_clk);
		s_axi_wstrb <= 4'h2;
		lvl(STATUS_OFF, 32'he0, 4'h2);
		@(posedge sys_clk);
		s_axi_wstrb <= 4'h3;
		edges(5'h15);
		edges(5'h0a);
		wr(ICTL2_OFF, 32'hc00a);
		rd(ICTL2_OFF);
		chk("ctl2", 32'h800a, d);
		@(posedge sys_clk);
		hold_cmd <= '1;
		rd(ICTL2_OFF);
		chk("ctl2", 32'hc00a, d);
		rd(4'h1);
		chk("rresp", 32'(RESP_SLVERR), 32'(r));
		// mid-run reset, held past the edge where the level drops so the checker stays quiet
		@(posedge sys_clk);
		reset_n <= '0;
		repeat (4) @(posedge sys_clk);
		reset_n <= '1;
		chk("rst prio", 32'h0, 32'(cpu_priority));
		rd(ICTL2_OFF);
		chk("rst ctl2", 32'h4000, d);
		test_done;
	end
endmodule : test_prio_edge_ctrl
